// >>> common/quad_map.svh
// register map, field positions, reset values and timing counts of the divided pulse output
`ifndef QUAD_MAP_SVH
`define QUAD_MAP_SVH
`define OFS_CTRL        8'h00
`define OFS_PPR         8'h04
`define OFS_ACTIVE      8'h08
`define OFS_STATUS      8'h0C
`define OFS_MASK        8'h10
`define OFS_SPD_LIMIT   8'h14
`define OFS_SPD_MEAS    8'h18
`define CTRL_APPLY      0
`define CTRL_PULSE_ENC  1
`define CTRL_DIR        2
`define ST_SETERR       0
`define ST_OVSPD        1
`define PPR_RST         32'h00000200
`define PPR_MIN         32'h00000010
`define PPR_STEP1_MAX   32'h00004000
`define PPR_STEP2_MAX   32'h00008000
`define PPR_STEP4_MAX   32'h00010000
`define PPR_RNG1_MAX    32'h00001800
`define PPR_RNG2_MAX    32'h00002000
`define RPM_RNG1        16'h3E80
`define RPM_RNG2        16'h2EE0
`define RPM_RNG3        16'h1770
`define RPM_RNG4        16'h0BB8
`define RPM_RNG5        16'h05DC
`define ENC_CPR         19'h40000
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define CLK_NS          100
`define SPD_WIN_NS      1000000
`define SPD_WIN_CYC     ((`SPD_WIN_NS) / (`CLK_NS))
`define NS_PER_MIN      64'd60000000000
`endif

// >>> common/quad_pkg.sv
// types shared by the divided pulse output block
package quad_pkg;
  typedef enum logic [0:0] {
    IDX_IDLE = 1'b0,
    IDX_HIGH = 1'b1
  } index_state_t;
  typedef logic [18:0] acc_t;
  typedef logic [31:0] word_t;
endpackage

// >>> design/quad_phase_gen.sv
// two phase quadrature state stepper, one gray step per enable
`timescale 1ns/1ns
`default_nettype none
module quad_phase_gen (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic step,
  input  wire logic rev,
  output logic      phase_a,
  output logic      phase_b
);
  logic [1:0] st_ff;
  logic [1:0] nxt_st;

  // forward walks ab 00,10,11,01; reverse walks the other way
  always_comb begin
    nxt_st = st_ff;
    if (step) begin
      case ({rev, st_ff})
        3'h0:    nxt_st = 2'h2;
        3'h2:    nxt_st = 2'h3;
        3'h3:    nxt_st = 2'h1;
        3'h1:    nxt_st = 2'h0;
        3'h4:    nxt_st = 2'h1;
        3'h5:    nxt_st = 2'h3;
        3'h7:    nxt_st = 2'h2;
        default: nxt_st = 2'h0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= 2'h0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign phase_a = st_ff[1];
  assign phase_b = st_ff[0];
endmodule
`default_nettype wire

// >>> design/encoder_divided_pulse_output.sv
// encoder divided pulse output: divider, quadrature, index, alarms and AXI4-Lite registers
// Function
// - phases A and B quarter cycle apart
// - pulse encoder passes straight through
// - serial encoder divided to set pulse count
// - one index pulse each revolution
// - index width equals phase A width
// - reverse select keeps same phase form
// - pulse count steps 1, 2, 4 by range
// - bad pulse count raises setting alarm
// - overspeed for count raises overspeed alarm
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "quad_map.svh"
module encoder_divided_pulse_output
  import quad_pkg::*;
#(
  parameter int unsigned SPD_WIN_CYC = `SPD_WIN_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        ser_step,
  input  wire logic        ser_dir,
  input  wire logic        ser_index,
  input  wire logic        pls_a,
  input  wire logic        pls_b,
  input  wire logic        pls_index,
  output logic             quad_out_a,
  output logic             quad_out_a_n,
  output logic             quad_out_b,
  output logic             quad_out_b_n,
  output logic             index_out,
  output logic             index_out_n,
  output logic [15:0]      speed_limit_rpm,
  output logic             irq
);
  // pulse count check: step 1, 2 or 4 by range
  function automatic logic ppr_ok(input word_t p);
    if (p < `PPR_MIN || p > `PPR_STEP4_MAX) return 1'b0;
    if (p <= `PPR_STEP1_MAX) return 1'b1;
    if (p <= `PPR_STEP2_MAX) return (p[0] == 1'b0);
    return (p[1:0] == 2'h0);
  endfunction

  function automatic logic [15:0] rpm_cap(input word_t p);
    if (p <= `PPR_RNG1_MAX) return `RPM_RNG1;
    if (p <= `PPR_RNG2_MAX) return `RPM_RNG2;
    if (p <= `PPR_STEP1_MAX) return `RPM_RNG3;
    if (p <= `PPR_STEP2_MAX) return `RPM_RNG4;
    return `RPM_RNG5;
  endfunction

  function automatic word_t merge(input word_t old, input word_t nw, input logic [3:0] st);
    word_t r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  logic        aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
  logic        nxt_aw_got, nxt_w_got, nxt_bvalid, nxt_rvalid;
  logic [7:0]  awaddr_ff, nxt_awaddr;
  word_t       wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
  logic [3:0]  wstrb_ff, nxt_wstrb;
  logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  word_t       ppr_ff, nxt_ppr, act_ppr_ff, nxt_act_ppr;
  logic        pend_pm_ff, nxt_pend_pm, pend_dir_ff, nxt_pend_dir;
  logic        pm_ff, nxt_pm, dir_ff, nxt_dir, cfg_ok_ff, nxt_cfg_ok;
  logic [1:0]  status_ff, nxt_status, mask_ff, nxt_mask;
  logic [15:0] spd_lim_ff, nxt_spd_lim;
  logic        wr_fire, apply, ovspd_evt;
  logic [7:0]  wa;
  word_t       wd;
  logic [3:0]  ws;
  logic [19:0] meas_ff, nxt_meas, win_cnt_ff, nxt_win_cnt, last_meas_ff, nxt_last_meas;
  longint      thr;

  // write channel accepts address and data in any order
  assign awready = !aw_got_ff && !bvalid_ff;
  assign wready  = !w_got_ff && !bvalid_ff;
  assign arready = !rvalid_ff;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;
  assign rvalid  = rvalid_ff;
  assign rdata   = rdata_ff;
  assign rresp   = rresp_ff;
  assign irq     = |(status_ff & mask_ff);
  assign speed_limit_rpm = spd_lim_ff;

  // bus slave and configuration registers
  always_comb begin
    nxt_aw_got = aw_got_ff;
    nxt_w_got  = w_got_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata  = wdata_ff;
    nxt_wstrb  = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp  = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    nxt_ppr = ppr_ff;
    nxt_pend_pm = pend_pm_ff;
    nxt_pend_dir = pend_dir_ff;
    nxt_mask = mask_ff;
    nxt_act_ppr = act_ppr_ff;
    nxt_pm = pm_ff;
    nxt_dir = dir_ff;
    nxt_cfg_ok = cfg_ok_ff;
    nxt_spd_lim = spd_lim_ff;
    apply = 1'b0;
    if (awvalid && awready) begin
      nxt_aw_got = 1'b1;
      nxt_awaddr = awaddr;
    end
    if (wvalid && wready) begin
      nxt_w_got = 1'b1;
      nxt_wdata = wdata;
      nxt_wstrb = wstrb;
    end
    wr_fire = nxt_aw_got && nxt_w_got && !bvalid_ff;
    wa = nxt_awaddr;
    wd = nxt_wdata;
    ws = nxt_wstrb;
    nxt_status = status_ff;
    if (wr_fire) begin
      nxt_aw_got = 1'b0;
      nxt_w_got  = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = `RESP_OKAY;
      case (wa)
        `OFS_CTRL: begin
          if (ws[0]) begin
            nxt_pend_pm  = wd[`CTRL_PULSE_ENC];
            nxt_pend_dir = wd[`CTRL_DIR];
            apply        = wd[`CTRL_APPLY];
          end
        end
        `OFS_PPR:    nxt_ppr = merge(ppr_ff, wd, ws);
        `OFS_STATUS: nxt_status = ws[0] ? (status_ff & ~wd[1:0]) : status_ff;
        `OFS_MASK:   nxt_mask = ws[0] ? wd[1:0] : mask_ff;
        `OFS_ACTIVE, `OFS_SPD_LIMIT, `OFS_SPD_MEAS: nxt_bresp = `RESP_OKAY;
        default:     nxt_bresp = `RESP_SLVERR;
      endcase
    end else if (bvalid_ff && bready) begin
      nxt_bvalid = 1'b0;
    end
    // settings become active only on a control write with the apply bit set; a bad count is refused
    if (apply) begin
      nxt_pm  = nxt_pend_pm;
      nxt_dir = nxt_pend_dir;
      if (ppr_ok(nxt_ppr)) begin
        nxt_act_ppr = nxt_ppr;
        nxt_cfg_ok  = 1'b1;
        nxt_spd_lim = rpm_cap(nxt_ppr);
      end else begin
        nxt_cfg_ok = 1'b0;
      end
    end
    if (apply && !ppr_ok(nxt_ppr)) nxt_status[`ST_SETERR] = 1'b1;
    if (ovspd_evt) nxt_status[`ST_OVSPD] = 1'b1;
    // read channel answers one cycle after the address is taken
    if (arvalid && arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = `RESP_OKAY;
      case (araddr)
        `OFS_CTRL:      nxt_rdata = {29'h0, pend_dir_ff, pend_pm_ff, 1'b0};
        `OFS_PPR:       nxt_rdata = ppr_ff;
        `OFS_ACTIVE:    nxt_rdata = act_ppr_ff;
        `OFS_STATUS:    nxt_rdata = {30'h0, status_ff};
        `OFS_MASK:      nxt_rdata = {30'h0, mask_ff};
        `OFS_SPD_LIMIT: nxt_rdata = {16'h0, spd_lim_ff};
        `OFS_SPD_MEAS:  nxt_rdata = {12'h0, last_meas_ff};
        default: begin
          nxt_rdata = 32'h0;
          nxt_rresp = `RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= `RESP_OKAY;
      ppr_ff <= `PPR_RST;
      pend_pm_ff <= 1'b0;
      pend_dir_ff <= 1'b0;
      status_ff <= 2'h0;
      mask_ff <= 2'h0;
      act_ppr_ff <= `PPR_RST;
      pm_ff <= 1'b0;
      dir_ff <= 1'b0;
      cfg_ok_ff <= 1'b1;
      spd_lim_ff <= `RPM_RNG1;
    end else begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      ppr_ff <= nxt_ppr;
      pend_pm_ff <= nxt_pend_pm;
      pend_dir_ff <= nxt_pend_dir;
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      act_ppr_ff <= nxt_act_ppr;
      pm_ff <= nxt_pm;
      dir_ff <= nxt_dir;
      cfg_ok_ff <= nxt_cfg_ok;
      spd_lim_ff <= nxt_spd_lim;
    end
  end

  acc_t         acc_ff, nxt_acc;
  acc_t         inc;
  logic         gen_step, eff_rev, gen_a, gen_b;
  index_state_t idx_ff, nxt_idx;
  logic [1:0]   idx_edges_ff, nxt_idx_edges;
  logic         pa_ff, pb_ff, pc_ff, nxt_pa, nxt_pb, nxt_pc;

  // active pulse count scaled by four edges per output pulse
  assign inc = act_ppr_ff[18:0] << 2;
  // direction select swaps count sense only
  assign eff_rev = ser_dir ^ dir_ff;

  // divider, index stretch, pass through and speed window
  always_comb begin
    nxt_acc = acc_ff;
    gen_step = 1'b0;
    nxt_idx = idx_ff;
    nxt_idx_edges = idx_edges_ff;
    nxt_meas = meas_ff;
    nxt_win_cnt = win_cnt_ff;
    nxt_last_meas = last_meas_ff;
    ovspd_evt = 1'b0;
    nxt_pa = pls_a;
    nxt_pb = pls_b;
    nxt_pc = pls_index;
    if (ser_step && cfg_ok_ff && !pm_ff) begin
      if (!eff_rev) begin
        if ({1'b0, acc_ff} + {1'b0, inc} >= {1'b0, `ENC_CPR}) begin
          nxt_acc = 19'(acc_ff + inc - `ENC_CPR);
          gen_step = 1'b1;
        end else begin
          nxt_acc = 19'(acc_ff + inc);
        end
      end else begin
        if (acc_ff < inc) begin
          nxt_acc = 19'(acc_ff + `ENC_CPR - inc);
          gen_step = 1'b1;
        end else begin
          nxt_acc = 19'(acc_ff - inc);
        end
      end
    end
    case (idx_ff)
      IDX_IDLE: begin
        if (ser_index && cfg_ok_ff && !pm_ff) begin
          nxt_idx = IDX_HIGH;
          nxt_idx_edges = 2'h0;
        end
      end
      IDX_HIGH: begin
        if (gen_step) begin
          nxt_idx_edges = 2'(idx_edges_ff + 2'h1);
          if (idx_edges_ff == 2'h1) nxt_idx = IDX_IDLE;
        end
      end
      default: nxt_idx = IDX_IDLE;
    endcase
    if (ser_step && !pm_ff) nxt_meas = 20'(meas_ff + 20'h1);
    if (win_cnt_ff == 20'(SPD_WIN_CYC - 1)) begin
      nxt_win_cnt = 20'h0;
      nxt_last_meas = nxt_meas;
      nxt_meas = 20'h0;
      if (64'(nxt_last_meas) > 64'(thr) && cfg_ok_ff && !pm_ff) ovspd_evt = 1'b1;
    end else begin
      nxt_win_cnt = 20'(win_cnt_ff + 20'h1);
    end
  end

  // encoder counts allowed per window at the capped speed
  assign thr = longint'((64'(spd_lim_ff) * 64'(`ENC_CPR) * 64'(SPD_WIN_CYC) * 64'(`CLK_NS)) / `NS_PER_MIN);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_ff <= 19'h0;
      idx_ff <= IDX_IDLE;
      idx_edges_ff <= 2'h0;
      pa_ff <= 1'b0;
      pb_ff <= 1'b0;
      pc_ff <= 1'b0;
      meas_ff <= 20'h0;
      win_cnt_ff <= 20'h0;
      last_meas_ff <= 20'h0;
    end else begin
      acc_ff <= nxt_acc;
      idx_ff <= nxt_idx;
      idx_edges_ff <= nxt_idx_edges;
      pa_ff <= nxt_pa;
      pb_ff <= nxt_pb;
      pc_ff <= nxt_pc;
      meas_ff <= nxt_meas;
      win_cnt_ff <= nxt_win_cnt;
      last_meas_ff <= nxt_last_meas;
    end
  end

  quad_phase_gen u_phase (
    .aclk    (aclk),
    .aresetn (aresetn),
    .step    (gen_step),
    .rev     (eff_rev),
    .phase_a (gen_a),
    .phase_b (gen_b)
  );

  assign quad_out_a = pm_ff ? pa_ff : gen_a;
  assign quad_out_b = pm_ff ? pb_ff : gen_b;
  assign index_out  = pm_ff ? pc_ff : (idx_ff == IDX_HIGH);
  assign quad_out_a_n = ~quad_out_a;
  assign quad_out_b_n = ~quad_out_b;
  assign index_out_n  = ~index_out;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_comp_pairs: assert property ((quad_out_a_n != quad_out_a) && (quad_out_b_n != quad_out_b)
    && (index_out_n != index_out))
    else $error("complementary pair broken");
  a_quarter_step: assert property (!pm_ff && $past(!pm_ff) |-> !($changed(quad_out_a) && $changed(quad_out_b)))
    else $error("both phases changed together");
  a_pass_thru: assert property (pm_ff && $past(pm_ff) |-> quad_out_b == $past(pls_b))
    else $error("pass through lag wrong");
  a_acc_bound: assert property (acc_ff < `ENC_CPR)
    else $error("divider residue out of range");
  a_index_cause: assert property ($rose(index_out) && !pm_ff && $past(!pm_ff) |-> $past(ser_index))
    else $error("index without encoder index");
  a_index_width: assert property ($fell(index_out) && !pm_ff && $past(!pm_ff) |-> $past(gen_step) && $past(idx_edges_ff) == 2'h1)
    else $error("index width not two edges");
  a_dir_form: assert property ($rose(quad_out_a) && !pm_ff && $past(!pm_ff) |-> quad_out_b == $past(eff_rev))
    else $error("phase form wrong for direction");
  a_reject_bad: assert property (apply && !ppr_ok(nxt_ppr) |=> $stable(act_ppr_ff) && !cfg_ok_ff)
    else $error("bad pulse count accepted");
  a_set_alarm: assert property (apply && !ppr_ok(nxt_ppr) |=> status_ff[`ST_SETERR] ##1 (irq || !mask_ff[0]))
    else $error("setting alarm missing");
  a_speed_cap: assert property (cfg_ok_ff && act_ppr_ff <= `PPR_RNG1_MAX |-> speed_limit_rpm == `RPM_RNG1)
    else $error("speed cap wrong for low range");
  a_ovspd_alarm: assert property (ovspd_evt |=> status_ff[`ST_OVSPD])
    else $error("overspeed alarm missing");

  c_apply_ok: cover property (apply && ppr_ok(nxt_ppr));
  c_index: cover property ($fell(index_out) && !pm_ff);
  c_ovspd: cover property (ovspd_evt);
  c_pass: cover property (pm_ff && $rose(quad_out_a));
endmodule
`default_nettype wire

// >>> tb/quad_host_model.sv
// host side model that decodes the quadrature pulses and measures widths
`timescale 1ns/1ns
`default_nettype none
module quad_host_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic a,
  input  wire logic a_n,
  input  wire logic b,
  input  wire logic b_n,
  input  wire logic c,
  input  wire logic c_n,
  output int        pos,
  output int        errs,
  output int        idx_cnt,
  output int        idx_w,
  output int        a_w
);
  logic [1:0] prv;
  int         cw;
  int         aw;
  // decode gray steps and measure pulse widths on each edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      prv = 2'h0;
    end else begin
      if (a_n !== ~a || b_n !== ~b || c_n !== ~c) errs++;
      case ({prv, a, b})
        4'h2, 4'hB, 4'hD, 4'h4: pos++;
        4'h1, 4'h7, 4'hE, 4'h8: pos--;
        4'h0, 4'h5, 4'hA, 4'hF: ;
        default: errs++;
      endcase
      prv = {a, b};
      if (c) cw++;
      else if (cw != 0) begin
        idx_w = cw;
        idx_cnt++;
        cw = 0;
      end
      if (a) aw++;
      else if (aw != 0) begin
        a_w = aw;
        aw = 0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the divided pulse output block
`timescale 1ns/1ns
`default_nettype none
`include "quad_map.svh"
module testbench;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd, ea;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic        ser_step, ser_dir, ser_index, pls_a, pls_b, pls_index;
  logic        qa, qa_n, qb, qb_n, qc, qc_n;
  logic [15:0] spd, ec;
  int          num_errors, checks_done, cyc, p0, pos, errs, idx_cnt, idx_w, a_w;
  localparam logic [31:0] PV [12] = '{16, 6144, 6145, 8193, 16384, 25000, 25001, 15,
                                      32770, 65537, 32772, 65536};
  localparam logic [15:0] CV [12] = '{16'h3E80, 16'h3E80, 16'h2EE0, 16'h1770, 16'h1770,
                                      16'h0BB8, 0, 0, 0, 0, 16'h05DC, 16'h05DC};
  localparam logic [1:0]  GR [4]  = '{2'h0, 2'h2, 2'h3, 2'h1};

  encoder_divided_pulse_output #(.SPD_WIN_CYC(100)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .ser_step(ser_step),
    .ser_dir(ser_dir), .ser_index(ser_index), .pls_a(pls_a), .pls_b(pls_b),
    .pls_index(pls_index), .quad_out_a(qa), .quad_out_a_n(qa_n), .quad_out_b(qb),
    .quad_out_b_n(qb_n), .index_out(qc), .index_out_n(qc_n), .speed_limit_rpm(spd), .irq(irq));

  quad_host_model u_host (
    .aclk(aclk), .aresetn(aresetn), .a(qa), .a_n(qa_n), .b(qb), .b_n(qb_n), .c(qc),
    .c_n(qc_n), .pos(pos), .errs(errs), .idx_cnt(idx_cnt), .idx_w(idx_w), .a_w(a_w));

  // free running clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task finish_test;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      $display("wrong value at %0t got %h expected %h", $time, g, e);
      num_errors++;
    end
  endtask

  // bus write, bready stays high all run
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk(bresp, r);
  endtask

  // bus read, rready stays high all run
  task rdt(input logic [7:0] a, input logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    chk(rresp, r);
  endtask

  // program a count and apply it
  task app(input logic [31:0] v, input logic [31:0] c);
    wr(`OFS_PPR, v, `RESP_OKAY);
    wr(`OFS_CTRL, c, `RESP_OKAY);
    repeat (2) @(posedge aclk);
  endtask

  // encoder counts with a gap of at least two cycles
  task stp(input int n, input int gap, input logic d);
    repeat (n) begin
      ser_step <= 1'b1;
      ser_dir <= d;
      @(posedge aclk);
      ser_step <= 1'b0;
      repeat (gap - 1) @(posedge aclk);
    end
  endtask

  initial begin
    {aresetn, awvalid, wvalid, arvalid, ser_step, ser_dir, ser_index} = '0;
    {pls_a, pls_b, pls_index, awaddr, araddr, wdata} = '0;
    {bready, rready} = 2'h3;
    wstrb = 4'hF;
    ea = `PPR_RST;
    ec = `RPM_RNG1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rdt(`OFS_PPR, `RESP_OKAY);
    chk(rd, `PPR_RST);
    chk(spd, `RPM_RNG1);
    rdt(8'h1C, `RESP_SLVERR);
    wr(8'h1C, 32'h0, `RESP_SLVERR);
    wr(`OFS_ACTIVE, 32'h20, `RESP_OKAY);
    rdt(`OFS_ACTIVE, `RESP_OKAY);
    chk(rd, `PPR_RST);
    wr(`OFS_MASK, 32'h3, `RESP_OKAY);
    $display("test reset done");
    // range and increment table, bad ones keep the old count
    for (int i = 0; i < 12; i++) begin
      app(PV[i], 32'h1);
      rdt(`OFS_STATUS, `RESP_OKAY);
      chk(rd[0], CV[i] == 16'h0);
      chk(irq, CV[i] == 16'h0);
      if (CV[i] != 16'h0) begin
        ea = PV[i];
        ec = CV[i];
      end
      wr(`OFS_STATUS, 32'h1, `RESP_OKAY);
      rdt(`OFS_ACTIVE, `RESP_OKAY);
      chk(rd, ea);
      chk(spd, ec);
    end
    rdt(`OFS_SPD_LIMIT, `RESP_OKAY);
    chk(rd, {16'h0, ec});
    $display("test table done");
    // slow turning, one count per four cycles
    p0 = idx_cnt;
    stp(4, 4, 1'b0);
    // index is a one-cycle pulse that rides on a count
    ser_index <= 1'b1;
    ser_step <= 1'b1;
    @(posedge aclk);
    ser_index <= 1'b0;
    ser_step <= 1'b0;
    repeat (3) @(posedge aclk);
    stp(6, 4, 1'b0);
    repeat (4) @(posedge aclk);
    chk(pos, 11);
    chk(idx_cnt - p0, 1);
    chk(idx_w, a_w);
    chk(errs, 0);
    $display("test quadrature done");
    // a count every cycle is far above the cap at this count
    ser_step <= 1'b1;
    repeat (250) @(posedge aclk);
    ser_step <= 1'b0;
    repeat (5) @(posedge aclk);
    rdt(`OFS_STATUS, `RESP_OKAY);
    chk(rd[1], 1'b1);
    chk(irq, 1'b1);
    wr(`OFS_MASK, 32'h1, `RESP_OKAY);
    @(posedge aclk);
    chk(irq, 1'b0);
    repeat (200) @(posedge aclk);
    wr(`OFS_STATUS, 32'h3, `RESP_OKAY);
    rdt(`OFS_STATUS, `RESP_OKAY);
    chk(rd, 32'h0);
    $display("test overspeed done");
    // at 16384 pulses one output edge needs four counts
    app(32'h4000, 32'h1);
    p0 = pos;
    stp(8, 2, 1'b0);
    repeat (4) @(posedge aclk);
    chk(pos - p0, 2);
    $display("test divider done");
    // reverse select with reverse counting keeps the forward form
    app(32'h10000, 32'h5);
    p0 = pos;
    stp(8, 4, 1'b1);
    repeat (4) @(posedge aclk);
    chk(pos - p0, 8);
    chk(errs, 0);
    $display("test reverse done");
    app(32'h200, 32'h3);
    for (int i = 0; i < 4; i++) begin
      {pls_a, pls_b} <= GR[i];
      pls_index <= GR[i][0];
      repeat (3) @(posedge aclk);
      chk({qa, qb, qc}, {GR[i], GR[i][0]});
    end
    $display("test pass-through done");
    finish_test();
  end
endmodule
`default_nettype wire
